// file: nmt_pkg.sv
// Constants for the node management tables block
package nmt_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES_DEF = (CLK_HZ / 1000000) * MS_US;
  localparam int NODES = 256;

  localparam logic [7:0] NODE_MIN = 8'h01;
  localparam logic [7:0] NODE_MAX = 8'hFE;
  localparam logic [15:0] AREA1_MAX = 16'h01FF;
  localparam logic [15:0] AREA2_MAX = 16'h1FFF;
  localparam logic [7:0] TWD_MIN = 8'h01;
  localparam logic [7:0] MFI_MAX = 8'h32;
  localparam logic [7:0] PROTO_VER = 8'h80;
  localparam logic [27:0] P2P_MAX = 28'hFFFFFFF;
  localparam logic [1:0] MISS_LIMIT = 2'h2;
  localparam logic [15:0] MEAS_MAX = 16'hFFFF;

  // Reset values of the local table
  localparam logic [7:0] NODE_RST = 8'h01;
  localparam logic [7:0] TWD_RST = 8'h32;
  localparam logic [7:0] MFI_RST = 8'h00;

  // Byte addresses of the register words
  localparam logic [6:0] A_NODE = 7'h00;
  localparam logic [6:0] A_AREA1 = 7'h04;
  localparam logic [6:0] A_AREA2 = 7'h08;
  localparam logic [6:0] A_ULTIM = 7'h0C;
  localparam logic [6:0] A_CTRL = 7'h10;
  localparam logic [6:0] A_IDENT = 7'h14;
  localparam int IDENT_WORDS = 8;
  localparam logic [6:0] A_PROTO = 7'h34;
  localparam logic [6:0] A_NET0 = 7'h38;
  localparam logic [6:0] A_MEAS0 = 7'h3C;
  localparam logic [6:0] A_MEAS1 = 7'h40;
  localparam logic [6:0] A_TXVER = 7'h44;
  localparam logic [6:0] A_TXP2P = 7'h48;
  localparam logic [6:0] A_TXBC = 7'h4C;
  localparam logic [6:0] A_RXVER = 7'h50;
  localparam logic [6:0] A_RXP2P = 7'h54;
  localparam logic [6:0] A_RXBC = 7'h58;
  localparam logic [6:0] A_PSEL = 7'h5C;
  localparam logic [6:0] A_PST = 7'h60;
  localparam logic [6:0] A_PA1 = 7'h64;
  localparam logic [6:0] A_PA2 = 7'h68;
  localparam logic [6:0] A_PREF = 7'h6C;

  // Fields of the control word
  localparam int CTRL_LOADED = 0;
  localparam int CTRL_LINK_LSB = 8;
  localparam int CTRL_OWN_LSB = 16;
  localparam int OWN_DUP_BIT = 0;
  localparam logic [7:0] LINK_IN = 8'h01;
  localparam logic [7:0] LINK_OUT = 8'h00;
endpackage

// file: nmt_top.sv
// Node management tables, participant tracking, refresh statistics and sequence counters
`timescale 1ns/1ps
module nmt_top
  import nmt_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [6:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic RX_TOKEN_I,
  input wire logic RX_JOIN_I,
  input wire logic [7:0] RX_SRC_NODE_I,
  input wire logic [7:0] RX_DST_NODE_I,
  input wire logic [15:0] RX_UL_STATUS_I,
  input wire logic [15:0] RX_A1_TOP_I,
  input wire logic [15:0] RX_A1_SIZE_I,
  input wire logic [15:0] RX_A2_TOP_I,
  input wire logic [15:0] RX_A2_SIZE_I,
  input wire logic [15:0] RX_REFRESH_I,
  input wire logic [7:0] RX_TWD_I,
  input wire logic [7:0] RX_MFI_I,
  input wire logic NET_CFG_WR_I,
  input wire logic [7:0] NET_CFG_NODE_I,
  input wire logic [15:0] NET_CFG_A1_TOP_I,
  input wire logic [15:0] NET_CFG_A1_SIZE_I,
  input wire logic [15:0] NET_CFG_A2_TOP_I,
  input wire logic [15:0] NET_CFG_A2_SIZE_I,
  output logic NET_CFG_REJECT_O,
  input wire logic TX_P2P_SENT_I,
  input wire logic TX_BC_SENT_I,
  input wire logic RX_MSG_I,
  input wire logic [31:0] RX_SEQ_VER_I,
  input wire logic [31:0] RX_SEQ_P2P_I,
  input wire logic [31:0] RX_SEQ_BC_I,
  output logic [7:0] LOC_NODE_O,
  output logic [15:0] LOC_A1_TOP_O,
  output logic [15:0] LOC_A1_SIZE_O,
  output logic [15:0] LOC_A2_TOP_O,
  output logic [15:0] LOC_A2_SIZE_O,
  output logic [15:0] LOC_UL_STATUS_O,
  output logic [7:0] LOC_TWD_O,
  output logic [7:0] LOC_MFI_O,
  output logic [7:0] LINK_PARTICIPATION_STATE_O,
  output logic TOKEN_REISSUE_O
);

  if (MS_CYCLES < 2) $error("MS_CYCLES must be at least 2");

  function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = nw[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic node_ok(input logic [7:0] n);
    return (n >= NODE_MIN) && (n <= NODE_MAX);
  endfunction

  // Local table
  logic [7:0] node_ff;
  logic [15:0] a1_top_ff, a1_size_ff, a2_top_ff, a2_size_ff, ul_ff;
  logic [7:0] twd_ff, mfi_ff;
  logic [31:0] ident_ff [0:IDENT_WORDS-1];
  logic loaded_ff, dup_ff, rej_ff;
  // Participant table, indexed by node number
  logic [NODES-1:0] present_ff, seen_ff;
  logic [1:0] miss_ff [0:NODES-1];
  logic [15:0] p_ul_ff [0:NODES-1];
  logic [15:0] p_a1t_ff [0:NODES-1];
  logic [15:0] p_a1s_ff [0:NODES-1];
  logic [15:0] p_a2t_ff [0:NODES-1];
  logic [15:0] p_a2s_ff [0:NODES-1];
  logic [15:0] p_ref_ff [0:NODES-1];
  logic [7:0] p_twd_ff [0:NODES-1];
  logic [7:0] p_mfi_ff [0:NODES-1];
  // Network table and statistics
  logic [7:0] holder_ff, psel_ff;
  logic [15:0] net_ref_ff, cur_ff, max_ff, min_ff, cyc_ff;
  logic first_tok_ff, meas_on_ff;
  logic [31:0] txver_ff, txp2p_ff, txbc_ff, rxver_ff, rxp2p_ff, rxbc_ff;
  logic [$clog2(MS_CYCLES)-1:0] div_ff;
  logic ms_tick;
  logic [7:0] wd_ff;
  logic reissue_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;

  wire logic wr_en = AVS_WRITE_I & ack_ff;
  wire logic [31:0] wmerged_node = bmerge({24'h0, node_ff}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire logic [31:0] wmerged_a1 = bmerge({a1_size_ff, a1_top_ff}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire logic [31:0] wmerged_a2 = bmerge({a2_size_ff, a2_top_ff}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire logic [31:0] wmerged_ut = bmerge({mfi_ff, twd_ff, ul_ff}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire logic [31:0] wmerged_sel = bmerge({24'h0, psel_ff}, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
  wire logic participating = loaded_ff & ~dup_ff;
  // Token and join frames count only once the host has loaded the table
  wire logic tok_v = RX_TOKEN_I & loaded_ff & node_ok(RX_SRC_NODE_I);
  wire logic join_v = RX_JOIN_I & loaded_ff & node_ok(RX_SRC_NODE_I);

  wire logic net_ok = node_ok(NET_CFG_NODE_I) && (NET_CFG_A1_TOP_I <= AREA1_MAX) &&
                      (NET_CFG_A1_SIZE_I <= AREA1_MAX) && (NET_CFG_A2_TOP_I <= AREA2_MAX) &&
                      (NET_CFG_A2_SIZE_I <= AREA2_MAX);
  wire logic net_wr = NET_CFG_WR_I & net_ok;

  // Ring helpers: lowest node, next node after the holder, widest frame interval
  logic [7:0] ring_min, ring_next, mfi_max;
  logic found_next;
  always_comb begin
    ring_min = 8'h00;
    ring_next = 8'h00;
    found_next = 1'b0;
    mfi_max = 8'h00;
    for (int i = NODES - 1; i >= 0; i--) begin
      if (present_ff[i] || (participating && node_ff == 8'(i))) begin
        ring_min = 8'(i);
        if (8'(i) > holder_ff) begin
          ring_next = 8'(i);
          found_next = 1'b1;
        end
      end
    end
    if (!found_next) ring_next = ring_min;
    for (int i = 0; i < NODES; i++) begin
      if (present_ff[i] && p_mfi_ff[i] > mfi_max) mfi_max = p_mfi_ff[i];
    end
    if (participating && mfi_ff > mfi_max) mfi_max = mfi_ff;
  end
  // Circulation starts when the lowest ring node is handed the token
  wire logic round_start = tok_v & (RX_DST_NODE_I == ring_min) & (ring_min != 8'h00);

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      node_ff <= NODE_RST;
      a1_top_ff <= 16'h0000;
      a1_size_ff <= 16'h0000;
      a2_top_ff <= 16'h0000;
      a2_size_ff <= 16'h0000;
    end else if (net_wr) begin
      node_ff <= NET_CFG_NODE_I;
      a1_top_ff <= NET_CFG_A1_TOP_I;
      a1_size_ff <= NET_CFG_A1_SIZE_I;
      a2_top_ff <= NET_CFG_A2_TOP_I;
      a2_size_ff <= NET_CFG_A2_SIZE_I;
    end else if (wr_en) begin
      if (AVS_ADDRESS_I == A_NODE && node_ok(wmerged_node[7:0])) node_ff <= wmerged_node[7:0];
      if (AVS_ADDRESS_I == A_AREA1 && wmerged_a1[15:0] <= AREA1_MAX && wmerged_a1[31:16] <= AREA1_MAX) begin
        a1_top_ff <= wmerged_a1[15:0];
        a1_size_ff <= wmerged_a1[31:16];
      end
      if (AVS_ADDRESS_I == A_AREA2 && wmerged_a2[15:0] <= AREA2_MAX && wmerged_a2[31:16] <= AREA2_MAX) begin
        a2_top_ff <= wmerged_a2[15:0];
        a2_size_ff <= wmerged_a2[31:16];
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ul_ff <= 16'h0000;
      twd_ff <= TWD_RST;
      mfi_ff <= MFI_RST;
    end else if (wr_en && AVS_ADDRESS_I == A_ULTIM) begin
      ul_ff <= wmerged_ut[15:0];
      if (wmerged_ut[23:16] >= TWD_MIN) twd_ff <= wmerged_ut[23:16];
      if (wmerged_ut[31:24] <= MFI_MAX) mfi_ff <= wmerged_ut[31:24];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      for (int w = 0; w < IDENT_WORDS; w++) ident_ff[w] <= 32'h00000000;
    end else if (wr_en) begin
      for (int w = 0; w < IDENT_WORDS; w++) begin
        if (AVS_ADDRESS_I == A_IDENT + 7'(4 * w)) ident_ff[w] <= bmerge(ident_ff[w], AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
    end
  end

  // duplicate flag; a new detection wins over a clear
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      loaded_ff <= 1'b0;
      dup_ff <= 1'b0;
      psel_ff <= 8'h00;
    end else begin
      if (wr_en && AVS_ADDRESS_I == A_CTRL && AVS_BYTEENABLE_I[0]) loaded_ff <= AVS_WRITEDATA_I[CTRL_LOADED];
      if (join_v && RX_SRC_NODE_I == node_ff) dup_ff <= 1'b1;
      else if (wr_en && AVS_ADDRESS_I == A_CTRL && AVS_BYTEENABLE_I[2] && AVS_WRITEDATA_I[CTRL_OWN_LSB + OWN_DUP_BIT])
        dup_ff <= 1'b0;
      if (wr_en && AVS_ADDRESS_I == A_PSEL) psel_ff <= wmerged_sel[7:0];
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) rej_ff <= 1'b0;
    else rej_ff <= NET_CFG_WR_I & ~net_ok;
  end

  always_ff @(posedge CLK_I) begin
    if ((tok_v || join_v) && RX_SRC_NODE_I != node_ff) begin
      p_ul_ff[RX_SRC_NODE_I] <= RX_UL_STATUS_I;
      p_a1t_ff[RX_SRC_NODE_I] <= RX_A1_TOP_I & AREA1_MAX;
      p_a1s_ff[RX_SRC_NODE_I] <= RX_A1_SIZE_I & AREA1_MAX;
      p_a2t_ff[RX_SRC_NODE_I] <= RX_A2_TOP_I & AREA2_MAX;
      p_a2s_ff[RX_SRC_NODE_I] <= RX_A2_SIZE_I & AREA2_MAX;
      p_ref_ff[RX_SRC_NODE_I] <= RX_REFRESH_I;
      p_twd_ff[RX_SRC_NODE_I] <= (RX_TWD_I < TWD_MIN) ? TWD_MIN : RX_TWD_I;
      p_mfi_ff[RX_SRC_NODE_I] <= (RX_MFI_I > MFI_MAX) ? MFI_MAX : RX_MFI_I;
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      present_ff <= '0;
      seen_ff <= '0;
      for (int i = 0; i < NODES; i++) miss_ff[i] <= 2'h0;
    end else if (!loaded_ff) begin
      present_ff <= '0;
      seen_ff <= '0;
    end else begin
      if (round_start) begin
        for (int i = 0; i < NODES; i++) begin
          if (seen_ff[i] || (8'(i) == RX_SRC_NODE_I)) miss_ff[i] <= 2'h0;
          else if (present_ff[i] && miss_ff[i] == MISS_LIMIT) begin
            present_ff[i] <= 1'b0;
            miss_ff[i] <= 2'h0;
          end else if (present_ff[i]) miss_ff[i] <= miss_ff[i] + 2'h1;
        end
        seen_ff <= '0;
      end
      // Sender marking comes last so it overrides a deletion in the same cycle
      if ((tok_v || join_v) && RX_SRC_NODE_I != node_ff) begin
        present_ff[RX_SRC_NODE_I] <= 1'b1;
        if (tok_v && !round_start) seen_ff[RX_SRC_NODE_I] <= 1'b1;
        if (join_v) miss_ff[RX_SRC_NODE_I] <= 2'h0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      holder_ff <= 8'h00;
      net_ref_ff <= 16'h0000;
      first_tok_ff <= 1'b0;
    end else if (!loaded_ff) begin
      first_tok_ff <= 1'b0;
    end else if (tok_v) begin
      first_tok_ff <= 1'b1;
      if (node_ok(RX_DST_NODE_I)) holder_ff <= RX_DST_NODE_I;
      net_ref_ff <= RX_REFRESH_I;
    end
  end

  // Millisecond enable shared by watchdog and measurement
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) div_ff <= '0;
    else if (div_ff == ($clog2(MS_CYCLES))'(MS_CYCLES - 1)) div_ff <= '0;
    else div_ff <= div_ff + 1'b1;
  end
  assign ms_tick = (div_ff == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

  // refresh cycle statistics, saturating at 65535
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cyc_ff <= 16'h0000;
      cur_ff <= 16'h0000;
      max_ff <= 16'h0000;
      min_ff <= MEAS_MAX;
      meas_on_ff <= 1'b0;
    end else if (round_start) begin
      cyc_ff <= 16'h0000;
      meas_on_ff <= 1'b1;
      if (meas_on_ff) begin
        cur_ff <= cyc_ff;
        if (cyc_ff > max_ff) max_ff <= cyc_ff;
        if (cyc_ff < min_ff) min_ff <= cyc_ff;
      end
    end else if (ms_tick && cyc_ff != MEAS_MAX) begin
      cyc_ff <= cyc_ff + 16'h0001;
    end
  end

  // token watchdog; only the ring successor of the silent holder reissues
  wire logic [7:0] wd_limit = (present_ff[holder_ff]) ? p_twd_ff[holder_ff] : twd_ff;
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wd_ff <= 8'h00;
      reissue_ff <= 1'b0;
    end else begin
      reissue_ff <= 1'b0;
      if (tok_v || !first_tok_ff || !participating) wd_ff <= 8'h00;
      else if (ms_tick) begin
        if (wd_ff + 8'h01 >= wd_limit) begin
          wd_ff <= 8'h00;
          reissue_ff <= (ring_next == node_ff);
        end else wd_ff <= wd_ff + 8'h01;
      end
    end
  end

  // sequence counters; broadcast skips zero, peer-to-peer stays in 28 bits
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      txver_ff <= 32'h00000001;
      txp2p_ff <= 32'h00000001;
      txbc_ff <= 32'h00000001;
      rxver_ff <= 32'h00000001;
      rxp2p_ff <= 32'h00000001;
      rxbc_ff <= 32'h00000001;
    end else begin
      if (wr_en && AVS_ADDRESS_I == A_TXVER) txver_ff <= bmerge(txver_ff, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      if (TX_P2P_SENT_I) txp2p_ff <= (txp2p_ff[27:0] >= P2P_MAX) ? 32'h00000001 : txp2p_ff + 32'h00000001;
      if (TX_BC_SENT_I) txbc_ff <= (txbc_ff == 32'hFFFFFFFF) ? 32'h00000001 : txbc_ff + 32'h00000001;
      if (RX_MSG_I) begin
        rxver_ff <= RX_SEQ_VER_I;
        rxp2p_ff <= RX_SEQ_P2P_I;
        rxbc_ff <= RX_SEQ_BC_I;
      end
    end
  end

  // link state, local and per peer
  wire logic [7:0] link_loc = participating ? LINK_IN : LINK_OUT;
  wire logic [7:0] link_peer = present_ff[psel_ff] ? LINK_IN : LINK_OUT;

  // Bus slave: one wait cycle, answer on the second edge
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h00000000;
    unique case (AVS_ADDRESS_I)
      A_NODE: rmux = {24'h0, node_ff};
      A_AREA1: rmux = {a1_size_ff, a1_top_ff};
      A_AREA2: rmux = {a2_size_ff, a2_top_ff};
      A_ULTIM: rmux = {mfi_ff, twd_ff, ul_ff};
      A_CTRL: rmux = {8'h00, 7'h00, dup_ff, link_loc, 7'h00, loaded_ff};
      A_PROTO: rmux = {24'h0, PROTO_VER};
      A_NET0: rmux = {net_ref_ff, mfi_max, holder_ff};
      A_MEAS0: rmux = {max_ff, cur_ff};
      A_MEAS1: rmux = {16'h0000, min_ff};
      A_TXVER: rmux = txver_ff;
      A_TXP2P: rmux = txp2p_ff;
      A_TXBC: rmux = txbc_ff;
      A_RXVER: rmux = rxver_ff;
      A_RXP2P: rmux = rxp2p_ff;
      A_RXBC: rmux = rxbc_ff;
      A_PSEL: rmux = {24'h0, psel_ff};
      A_PST: rmux = {p_mfi_ff[psel_ff], p_twd_ff[psel_ff], p_ul_ff[psel_ff]};
      A_PA1: rmux = {p_a1s_ff[psel_ff], p_a1t_ff[psel_ff]};
      A_PA2: rmux = {p_a2s_ff[psel_ff], p_a2t_ff[psel_ff]};
      A_PREF: rmux = {7'h00, present_ff[psel_ff], link_peer, p_ref_ff[psel_ff]};
      default: begin
        for (int w = 0; w < IDENT_WORDS; w++) begin
          if (AVS_ADDRESS_I == A_IDENT + 7'(4 * w)) rmux = ident_ff[w];
        end
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= (AVS_READ_I | AVS_WRITE_I) & ~ack_ff;
      if (AVS_READ_I && !ack_ff) rdata_ff <= rmux;
    end
  end

  assign AVS_WAITREQUEST_O = (AVS_READ_I | AVS_WRITE_I) & ~ack_ff;
  assign AVS_READDATA_O = rdata_ff;
  // frame builder sees the local table
  assign LOC_NODE_O = node_ff;
  assign LOC_A1_TOP_O = a1_top_ff;
  assign LOC_A1_SIZE_O = a1_size_ff;
  assign LOC_A2_TOP_O = a2_top_ff;
  assign LOC_A2_SIZE_O = a2_size_ff;
  assign LOC_UL_STATUS_O = ul_ff;
  assign LOC_TWD_O = twd_ff;
  assign LOC_MFI_O = mfi_ff;
  assign LINK_PARTICIPATION_STATE_O = link_loc;
  assign NET_CFG_REJECT_O = rej_ff;
  assign TOKEN_REISSUE_O = reissue_ff;
endmodule

// file: nmt_top_props.sv
// Checker for the node management tables
`timescale 1ns/1ps
module nmt_top_props
  import nmt_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic RX_TOKEN_I,
  input wire logic NET_CFG_WR_I,
  input wire logic [7:0] NET_CFG_NODE_I,
  input wire logic [15:0] NET_CFG_A1_TOP_I,
  input wire logic [15:0] NET_CFG_A1_SIZE_I,
  input wire logic [15:0] NET_CFG_A2_TOP_I,
  input wire logic [15:0] NET_CFG_A2_SIZE_I,
  input wire logic NET_CFG_REJECT_O,
  input wire logic [7:0] LOC_NODE_O,
  input wire logic [15:0] LOC_A1_TOP_O,
  input wire logic [15:0] LOC_A1_SIZE_O,
  input wire logic [15:0] LOC_A2_TOP_O,
  input wire logic [15:0] LOC_A2_SIZE_O,
  input wire logic [7:0] LOC_TWD_O,
  input wire logic [7:0] LOC_MFI_O,
  input wire logic [7:0] LINK_PARTICIPATION_STATE_O,
  input wire logic TOKEN_REISSUE_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [15:0] since_tok_ff;
  logic cfg_ok;
  assign cfg_ok = NET_CFG_NODE_I >= NODE_MIN && NET_CFG_NODE_I <= NODE_MAX && NET_CFG_A1_TOP_I <= AREA1_MAX
    && NET_CFG_A1_SIZE_I <= AREA1_MAX && NET_CFG_A2_TOP_I <= AREA2_MAX && NET_CFG_A2_SIZE_I <= AREA2_MAX;
  // Saturates so a long quiet spell never wraps back to zero
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      since_tok_ff <= 16'h0000;
    end else if (RX_TOKEN_I) begin
      since_tok_ff <= 16'h0000;
    end else if (since_tok_ff != 16'hFFFF) begin
      since_tok_ff <= since_tok_ff + 16'h0001;
    end
  end
  property p_wait_one;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer not after one wait cycle");
  property p_cfg_take;
    NET_CFG_WR_I && cfg_ok |=> LOC_NODE_O == $past(NET_CFG_NODE_I) && !NET_CFG_REJECT_O;
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("valid network write not stored");
  property p_cfg_reject;
    NET_CFG_WR_I && (NET_CFG_NODE_I == 8'h00 || NET_CFG_NODE_I == 8'hFF) && !AVS_WRITE_I
      |=> NET_CFG_REJECT_O && $stable(LOC_NODE_O);
  endproperty
  a_cfg_reject: assert property (p_cfg_reject) else $error("bad node write not refused");
  property p_node_range;
    LOC_NODE_O >= NODE_MIN && LOC_NODE_O <= NODE_MAX;
  endproperty
  a_node_range: assert property (p_node_range) else $error("node number out of range");
  property p_area1;
    LOC_A1_TOP_O <= AREA1_MAX && LOC_A1_SIZE_O <= AREA1_MAX;
  endproperty
  a_area1: assert property (p_area1) else $error("area 1 out of range");
  property p_area2;
    LOC_A2_TOP_O <= AREA2_MAX && LOC_A2_SIZE_O <= AREA2_MAX;
  endproperty
  a_area2: assert property (p_area2) else $error("area 2 out of range");
  property p_twd;
    LOC_TWD_O != 8'h00;
  endproperty
  a_twd: assert property (p_twd) else $error("watchdog setting zero");
  property p_mfi;
    LOC_MFI_O <= MFI_MAX;
  endproperty
  a_mfi: assert property (p_mfi) else $error("frame interval above limit");
  property p_link;
    LINK_PARTICIPATION_STATE_O == LINK_IN || LINK_PARTICIPATION_STATE_O == LINK_OUT;
  endproperty
  a_link: assert property (p_link) else $error("link state code unknown");
  property p_reissue;
    TOKEN_REISSUE_O |-> since_tok_ff >= 16'(MS_CYCLES / 2) && !$past(TOKEN_REISSUE_O);
  endproperty
  a_reissue: assert property (p_reissue) else $error("token reissued too early");
  c_reissue: cover property (TOKEN_REISSUE_O);
  c_reject: cover property (NET_CFG_REJECT_O);
  c_token: cover property (RX_TOKEN_I);
endmodule
bind nmt_top nmt_top_props #(.MS_CYCLES(MS_CYCLES)) u_props (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .RX_TOKEN_I(RX_TOKEN_I), .NET_CFG_WR_I(NET_CFG_WR_I), .NET_CFG_NODE_I(NET_CFG_NODE_I),
  .NET_CFG_A1_TOP_I(NET_CFG_A1_TOP_I), .NET_CFG_A1_SIZE_I(NET_CFG_A1_SIZE_I),
  .NET_CFG_A2_TOP_I(NET_CFG_A2_TOP_I), .NET_CFG_A2_SIZE_I(NET_CFG_A2_SIZE_I),
  .NET_CFG_REJECT_O(NET_CFG_REJECT_O), .LOC_NODE_O(LOC_NODE_O), .LOC_A1_TOP_O(LOC_A1_TOP_O),
  .LOC_A1_SIZE_O(LOC_A1_SIZE_O), .LOC_A2_TOP_O(LOC_A2_TOP_O), .LOC_A2_SIZE_O(LOC_A2_SIZE_O),
  .LOC_TWD_O(LOC_TWD_O), .LOC_MFI_O(LOC_MFI_O), .LINK_PARTICIPATION_STATE_O(LINK_PARTICIPATION_STATE_O),
  .TOKEN_REISSUE_O(TOKEN_REISSUE_O));

// file: nmt_peer_model.sv
// Remote node model: token, join and configuration frames
`timescale 1ns/1ps
module nmt_peer_model (
  input wire logic clk_i,
  output logic tok_o,
  output logic join_o,
  output logic cfg_wr_o,
  output logic [7:0] src_o,
  output logic [7:0] dst_o,
  output logic [15:0] ul_o,
  output logic [15:0] a1t_o,
  output logic [15:0] a1s_o,
  output logic [15:0] a2t_o,
  output logic [15:0] a2s_o,
  output logic [15:0] ref_o,
  output logic [7:0] twd_o,
  output logic [7:0] mfi_o
);
  // Table fields held legal; a 2 ms watchdog keeps the reissue wait short
  initial begin
    tok_o = 1'b0;
    join_o = 1'b0;
    cfg_wr_o = 1'b0;
    src_o = 8'h00;
    dst_o = 8'h00;
    ul_o = 16'h0001;
    a1t_o = 16'h0000;
    a1s_o = 16'h0010;
    a2t_o = 16'h0000;
    a2s_o = 16'h0020;
    ref_o = 16'h0064;
    twd_o = 8'h02;
    mfi_o = 8'h05;
  end
  task automatic send(input logic [1:0] k, input logic [7:0] s, input logic [7:0] d);
    @(posedge clk_i);
    tok_o <= k == 2'h0;
    join_o <= k == 2'h1;
    cfg_wr_o <= k == 2'h2;
    src_o <= s;
    dst_o <= d;
    @(posedge clk_i);
    tok_o <= 1'b0;
    join_o <= 1'b0;
    cfg_wr_o <= 1'b0;
    // Released fields must not keep the last value
    src_o <= ~s;
    dst_o <= ~d;
  endtask
endmodule

// file: node_management_tables_bench.sv
// Self-checking bench for the node management tables
`timescale 1ns/1ps
module node_management_tables_bench
  import nmt_pkg::*;
  ;
  typedef struct packed {logic w; logic [6:0] a; logic [31:0] d; logic [31:0] e;} nmt_row_t;
  logic clk, rst_n, rd, wr, txp, txb, rxm, wreq, rej, reis, tok, jn, cw;
  logic [6:0] adr;
  logic [31:0] wd, rdata, rdat, seq;
  logic [7:0] src, dst, twd, mfi, lnode, link;
  logic [15:0] ul, a1t, a1s, a2t, a2s, rf, ulo;
  int failures, check_count, n;
  nmt_row_t rows [16] = '{
    '{1'b0, A_NODE, 32'h0, 32'h1}, '{1'b0, A_ULTIM, 32'h0, 32'h00320000}, '{1'b0, A_TXBC, 32'h0, 32'h1},
    '{1'b1, A_PROTO, 32'h0, 32'h80}, '{1'b1, A_NODE, 32'h0, 32'h1}, '{1'b1, A_NODE, 32'hFF, 32'h1},
    '{1'b1, A_NODE, 32'hFE, 32'hFE}, '{1'b1, A_NODE, 32'h3, 32'h3}, '{1'b1, A_AREA1, 32'h01FF01FF, 32'h01FF01FF},
    '{1'b1, A_AREA1, 32'h00100200, 32'h01FF01FF}, '{1'b1, A_AREA2, 32'h1FFF1FFF, 32'h1FFF1FFF},
    '{1'b1, A_AREA2, 32'h00002000, 32'h1FFF1FFF}, '{1'b1, A_ULTIM, 32'h32FFABCD, 32'h32FFABCD},
    '{1'b1, A_ULTIM, 32'h33FF1234, 32'h32FF1234}, '{1'b1, 7'h7C, 32'h12345678, 32'h0},
    '{1'b1, A_IDENT, 32'h44332211, 32'h44332211}};
  nmt_top #(.MS_CYCLES(10)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .RX_TOKEN_I(tok), .RX_JOIN_I(jn), .RX_SRC_NODE_I(src), .RX_DST_NODE_I(dst),
    .RX_UL_STATUS_I(ul), .RX_A1_TOP_I(a1t), .RX_A1_SIZE_I(a1s), .RX_A2_TOP_I(a2t), .RX_A2_SIZE_I(a2s),
    .RX_REFRESH_I(rf), .RX_TWD_I(twd), .RX_MFI_I(mfi), .NET_CFG_WR_I(cw), .NET_CFG_NODE_I(src),
    .NET_CFG_A1_TOP_I(a1t), .NET_CFG_A1_SIZE_I(a1s), .NET_CFG_A2_TOP_I(a2t), .NET_CFG_A2_SIZE_I(a2s),
    .NET_CFG_REJECT_O(rej), .TX_P2P_SENT_I(txp), .TX_BC_SENT_I(txb), .RX_MSG_I(rxm), .RX_SEQ_VER_I(seq),
    .RX_SEQ_P2P_I(seq), .RX_SEQ_BC_I(seq), .LOC_NODE_O(lnode), .LOC_A1_TOP_O(), .LOC_A1_SIZE_O(),
    .LOC_A2_TOP_O(), .LOC_A2_SIZE_O(), .LOC_UL_STATUS_O(ulo), .LOC_TWD_O(), .LOC_MFI_O(),
    .LINK_PARTICIPATION_STATE_O(link), .TOKEN_REISSUE_O(reis));
  nmt_peer_model u_peer (.clk_i(clk), .tok_o(tok), .join_o(jn), .cfg_wr_o(cw), .src_o(src), .dst_o(dst),
    .ul_o(ul), .a1t_o(a1t), .a1s_o(a1s), .a2t_o(a2t), .a2s_o(a2s), .ref_o(rf), .twd_o(twd), .mfi_o(mfi));
  task automatic finish_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    if (wreq !== 1'b0) begin
      failures++;
      finish_test();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic present(input logic [7:0] p, input logic e);
    bus(1'b1, A_PSEL, {24'h0, p}, rdat);
    bus(1'b0, A_PREF, 32'h0, rdat);
    chk("present", {31'h0, e}, {31'h0, rdat[24]});
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    {rst_n, rd, wr, txp, txb, rxm, adr, wd, seq} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d, rdat);
      bus(1'b0, rows[i].a, 32'h0, rdat);
      chk("reg", rows[i].e, rdat);
    end
    chk("loc_node", 32'h3, {24'h0, lnode});
    chk("loc_ul", 32'h1234, {16'h0, ulo});
    $display("register table test done");
    u_peer.send(2'h0, 8'h05, 8'h07);
    present(8'h05, 1'b0);
    bus(1'b1, A_CTRL, 32'h1, rdat);
    chk("link", 32'h1, {24'h0, link});
    u_peer.send(2'h0, 8'h07, 8'h05);
    u_peer.send(2'h0, 8'h05, 8'h03);
    present(8'h07, 1'b1);
    bus(1'b0, A_PA1, 32'h0, rdat);
    chk("peer_a1", 32'h00100000, rdat);
    bus(1'b0, A_NET0, 32'h0, rdat);
    chk("holder", 32'h3, {24'h0, rdat[7:0]});
    u_peer.send(2'h0, 8'h05, 8'h03);
    u_peer.send(2'h0, 8'h05, 8'h03);
    present(8'h07, 1'b1);
    u_peer.send(2'h0, 8'h05, 8'h03);
    present(8'h07, 1'b0);
    $display("participant test done");
    u_peer.send(2'h0, 8'h05, 8'h05);
    n = 0;
    while (reis !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("reissue_gap", 32'h1, {31'h0, n >= 12 && n <= 21});
    $display("watchdog test done");
    u_peer.send(2'h1, 8'h09, 8'h00);
    present(8'h09, 1'b1);
    u_peer.send(2'h1, 8'h03, 8'h00);
    bus(1'b0, A_CTRL, 32'h0, rdat);
    chk("dup", 32'h1, {31'h0, rdat[16]});
    chk("link_dup", 32'h0, {24'h0, link});
    bus(1'b1, A_CTRL, 32'h00010001, rdat);
    chk("link_clr", 32'h1, {24'h0, link});
    $display("join test done");
    @(posedge clk);
    {txb, txp, rxm} <= 3'b111;
    seq <= 32'h7;
    @(posedge clk);
    {txb, txp, rxm} <= 3'b000;
    bus(1'b0, A_TXBC, 32'h0, rdat);
    chk("tx_bc", 32'h2, rdat);
    bus(1'b0, A_TXP2P, 32'h0, rdat);
    chk("tx_p2p", 32'h2, rdat);
    bus(1'b0, A_RXBC, 32'h0, rdat);
    chk("rx_bc", 32'h7, rdat);
    $display("sequence test done");
    u_peer.send(2'h2, 8'h00, 8'h00);
    @(negedge clk);
    chk("reject", 32'h1, {31'h0, rej});
    u_peer.send(2'h2, 8'h09, 8'h00);
    @(negedge clk);
    chk("net_node", 32'h9, {24'h0, lnode});
    $display("network write test done");
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk("rst_node", 32'h1, {24'h0, lnode});
    chk("rst_link", 32'h0, {24'h0, link});
    @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, A_CTRL, 32'h0, rdat);
    chk("rst_ctrl", 32'h0, rdat);
    $display("reset test done");
    finish_test();
  end
endmodule
